// ---- rtl/seew_params.svh ----
`ifndef SEEW_PARAMS_SVH
`define SEEW_PARAMS_SVH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define SEEW_OPC_ARM        8'h06
`define SEEW_OPC_DISARM     8'h04
`define SEEW_OPC_FLAGS_RD   8'h05
`define SEEW_OPC_FLAGS_WR   8'h01
`define SEEW_OPC_HI_ZERO    4'h0
`define SEEW_OPC_ARRAY_WR   3'h2
`define SEEW_OPC_ARRAY_RD   3'h3
`define SEEW_OPC_A8_BIT     3

// ----------------------------------------------------------------------------
// Flag byte layout and protection levels
// ----------------------------------------------------------------------------
`define SEEW_FLAGS_PAD      4'h0
`define SEEW_BP_HI_BIT      3
`define SEEW_BP_LO_BIT      2
`define SEEW_BP_RESET       2'h0
`define SEEW_LVL_NONE       2'h0
`define SEEW_LVL_TOP_QUART  2'h1
`define SEEW_LVL_TOP_HALF   2'h2
`define SEEW_LVL_ALL        2'h3
`define SEEW_PROT_QUART     9'h180
`define SEEW_PROT_HALF      9'h100

// ----------------------------------------------------------------------------
// Serial framing and timing
// ----------------------------------------------------------------------------
`define SEEW_BIT_FIRST      3'h0
`define SEEW_BIT_LAST       3'h7
`define SEEW_BIT_STEP       3'h1
`define SEEW_PAGE_STEP      2'h1
`define SEEW_PAGE_FIRST     2'h0
`define SEEW_PAGE_LAST      2'h3
`define SEEW_PAGE_NONE      4'h0
`define SEEW_PAGE_BYTES     4
`define SEEW_CLK_PERIOD_NS  4
`define SEEW_PROG_TIME_NS   10000000

`endif

// ---- rtl/seew_pkg.sv ----
`include "seew_params.svh"

package seew_pkg;

   typedef enum logic [2:0] {
      LS_OPC     = 3'b000,
      LS_ADDR    = 3'b001,
      LS_DATA    = 3'b010,
      LS_BPDAT   = 3'b011,
      LS_STAT    = 3'b100,
      LS_REST    = 3'b101,
      LS_INVALID = 3'b110
   } seew_lstate_t;

   typedef enum logic [2:0] {
      CK_NONE     = 3'b000,
      CK_ARM      = 3'b001,
      CK_DISARM   = 3'b010,
      CK_FLAGS_WR = 3'b011,
      CK_WRITE    = 3'b100
   } seew_kind_t;

   typedef struct packed {
      seew_kind_t  kind;
      logic [8:0]  addr;
      logic [1:0]  bp;
   } seew_cmd_t;

   typedef struct packed {
      logic [1:0]  bp;
      logic        wen;
      logic        busy;
   } seew_stat_t;

   typedef struct packed {
      logic        en;
      logic [8:0]  addr;
      logic [7:0]  data;
   } seew_arr_wr_t;

   function automatic seew_kind_t seew_opc_kind(input logic [7:0] opc);
      seew_kind_t k;
      k = CK_NONE;
      if (opc == `SEEW_OPC_ARM)
         k = CK_ARM;
      else if (opc == `SEEW_OPC_DISARM)
         k = CK_DISARM;
      else if (opc == `SEEW_OPC_FLAGS_WR)
         k = CK_FLAGS_WR;
      else if (opc[7:4] == `SEEW_OPC_HI_ZERO && opc[2:0] == `SEEW_OPC_ARRAY_WR)
         k = CK_WRITE;
      return k;
   endfunction

   function automatic logic seew_prot_hit(input logic [1:0] lvl, input logic [8:0] addr);
      logic hit;
      hit = 1'b0;
      case (lvl)
         `SEEW_LVL_NONE:      hit = 1'b0;
         `SEEW_LVL_TOP_QUART: hit = (addr >= `SEEW_PROT_QUART);
         `SEEW_LVL_TOP_HALF:  hit = (addr >= `SEEW_PROT_HALF);
         `SEEW_LVL_ALL:       hit = 1'b1;
         default:             hit = 1'b1;
      endcase
      return hit;
   endfunction

endpackage

// ---- rtl/seew_prog_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module seew_prog_timer #(
   parameter int unsigned PROG_CYCLES = 1
) (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   import seew_pkg::*;

   logic [31:0] cnt_r;
   logic        busy_r;

   // The self-timed cycle runs to its end once started; only reset can cut it short.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         busy_r <= 1'b0;
         cnt_r  <= 32'h0;
      end
      else if (start && !busy_r)
      begin
         busy_r <= 1'b1;
         cnt_r  <= PROG_CYCLES - 32'h1;
      end
      else if (busy_r)
      begin
         if (cnt_r == 32'h0)
            busy_r <= 1'b0;
         else
            cnt_r <= cnt_r - 32'h1;
      end
   end

   assign busy = busy_r;
   assign done = busy_r && (cnt_r == 32'h0);

   AST_DONE_ENDS_BUSY: assert property (@(posedge clock) disable iff (!reset_n) // [RULE3]
      done |=> !busy_r)
      else $error("busy did not fall after the programming cycle ended");

endmodule

`default_nettype wire

// ---- rtl/seew_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "seew_params.svh"

// Function
// [RULE1] Flag byte: bits 3..2 show protect level
// [RULE2] Bit 1 shows the write arm latch
// [RULE3] Bit 0 shows programming in progress
// [RULE4] During programming only bit 0 matters
// [RULE5] Flag read shifts byte out MSB first
// [RULE6] Write arm latch clear after reset
// [RULE7] Disarm command clears the write arm latch
// [RULE8] Array write needs guard high, armed, unprotected
// [RULE9] Protect levels cover none, quarter, half, all
// [RULE10] Byte write: opcode, address, data, MSB first
// [RULE11] Array programming starts on chip select rise
// [RULE12] While busy only flag read is honoured
// [RULE13] Master polls busy before next command
// [RULE14] Page of four bytes, low address wraps
// [RULE15] Array programming end disarms writes
// [RULE16] Unarmed write command is ignored entirely
// [RULE17] Flag write keeps only received bits 3..2
// [RULE18] Flag write needs guard high and armed
// [RULE19] Flag programming starts on chip select rise
// [RULE20] Flag programming end disarms writes
// [RULE21] Invalid opcode: no shifting, output floats
// [RULE22] Opcode encodings, address bit 8 in opcode
// [RULE23] Sample on rising, drive on falling edges
// [RULE24] Guard low blocks, running cycle completes
// [RULE25] Chip select rise aborts partial command
module seew_ctrl #(
   parameter int unsigned PROG_CYCLES =
      (`SEEW_PROG_TIME_NS + `SEEW_CLK_PERIOD_NS - 1) / `SEEW_CLK_PERIOD_NS
) (
   input  wire logic           clock,
   input  wire logic           reset_n,
   input  wire logic           sck,
   input  wire logic           cs_n,
   input  wire logic           si,
   input  wire logic           wp_n,
   output logic                so_out,
   output logic                so_oe,
   output seew_pkg::seew_arr_wr_t array_wr
);
   import seew_pkg::*;

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   seew_lstate_t state_r;
   logic [2:0]   bit_cnt_r;
   logic [7:0]   shift_r;
   logic [7:0]   byte_w;
   logic         last_w;
   seew_cmd_t    cmd_r;
   logic [3:0]   loaded_r;
   logic [7:0]   page_r [0:`SEEW_PAGE_BYTES-1];
   logic         frame_tog_r;
   logic         complete_r;
   logic         link_rst_r;
   seew_stat_t   stat_meta_r;
   seew_stat_t   stat_sync_r;
   logic [2:0]   out_idx_r;
   logic [7:0]   stat_byte_w;
   logic         so_r;
   logic         so_oe_r;

   logic         cs_meta_r;
   logic         cs_sync_r;
   logic         cs_prev_r;
   logic         wp_meta_r;
   logic         wp_sync_r;
   logic         tog_meta_r;
   logic         tog_sync_r;
   logic         tog_seen_r;
   logic         comp_meta_r;
   logic         comp_sync_r;
   logic         cs_rise_w;
   logic         commit_w;
   logic         busy_w;
   logic         done_w;
   logic         start_arr_w;
   logic         start_bp_w;
   logic         wen_r;
   logic [1:0]   bp_r;
   seew_stat_t   stat_w;
   logic [8:0]   wr_base_r;
   logic [3:0]   wr_mask_r;
   logic [7:0]   wr_page_r [0:`SEEW_PAGE_BYTES-1];
   logic [1:0]   wr_idx_r;
   logic         wr_act_r;
   seew_arr_wr_t arr_wr_r;

   function automatic seew_lstate_t opc_state(input logic [7:0] opc);
      seew_lstate_t s;
      s = LS_INVALID;
      case (seew_opc_kind(opc))
         CK_ARM:      s = LS_REST;
         CK_DISARM:   s = LS_REST;
         CK_FLAGS_WR: s = LS_BPDAT;
         CK_WRITE:    s = LS_ADDR;
         CK_NONE:
         begin
            if (opc == `SEEW_OPC_FLAGS_RD)
               s = LS_STAT;
            else if (opc[7:4] == `SEEW_OPC_HI_ZERO && opc[2:0] == `SEEW_OPC_ARRAY_RD)
               s = LS_REST;
            else
               s = LS_INVALID;
         end
         default:     s = LS_INVALID;
      endcase
      return s;
   endfunction

   // -------------------------------------------------------------------------
   // Link side: receive on rising serial clock edges
   // -------------------------------------------------------------------------
   assign byte_w = {shift_r[6:0], si};
   assign last_w = (bit_cnt_r == `SEEW_BIT_LAST);

   // Chip select high holds the receiver in reset, so a partial command dies.
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         state_r   <= LS_OPC;                                    // [RULE25]
         bit_cnt_r <= `SEEW_BIT_FIRST;
         shift_r   <= 8'h00;
      end
      else
      begin
         if (state_r == LS_OPC || state_r == LS_ADDR ||
             state_r == LS_DATA || state_r == LS_BPDAT)
         begin
            shift_r   <= byte_w;                                 // [RULE23]
            bit_cnt_r <= bit_cnt_r + `SEEW_BIT_STEP;
         end
         if (last_w)
         begin
            case (state_r)
               LS_OPC:   state_r <= opc_state(byte_w);           // [RULE22] [RULE21]
               LS_ADDR:  state_r <= LS_DATA;
               LS_BPDAT: state_r <= LS_REST;
               default:  state_r <= state_r;
            endcase
         end
      end
   end

   // Command record survives chip select so the system side can read it after.
   always_ff @(posedge sck or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         frame_tog_r <= 1'b0;
         complete_r  <= 1'b0;
         cmd_r       <= '0;
         loaded_r    <= `SEEW_PAGE_NONE;
      end
      else if (!cs_n)
      begin
         complete_r <= 1'b0;
         if (state_r == LS_OPC && bit_cnt_r == `SEEW_BIT_FIRST)
            frame_tog_r <= ~frame_tog_r;
         if (last_w)
         begin
            case (state_r)
               LS_OPC:
               begin
                  cmd_r.kind                 <= seew_opc_kind(byte_w);
                  cmd_r.addr[8]              <= byte_w[`SEEW_OPC_A8_BIT]; // [RULE22]
                  loaded_r                   <= `SEEW_PAGE_NONE;
                  complete_r <= (seew_opc_kind(byte_w) == CK_ARM) ||
                                (seew_opc_kind(byte_w) == CK_DISARM);
               end
               LS_ADDR:  cmd_r.addr[7:0] <= byte_w;                   // [RULE10]
               LS_DATA:
               begin
                  loaded_r[cmd_r.addr[1:0]] <= 1'b1;
                  cmd_r.addr[1:0]           <= cmd_r.addr[1:0] + `SEEW_PAGE_STEP; // [RULE14]
                  complete_r                <= 1'b1;                  // [RULE11]
               end
               LS_BPDAT:
               begin
                  cmd_r.bp   <= byte_w[`SEEW_BP_HI_BIT:`SEEW_BP_LO_BIT]; // [RULE17]
                  complete_r <= 1'b1;                                  // [RULE19]
               end
               default:  complete_r <= 1'b0;
            endcase
         end
      end
   end

   // Later bytes of a page overwrite earlier ones once the low address wraps.
   always_ff @(posedge sck)
   begin
      if (!cs_n && last_w && state_r == LS_DATA)
         page_r[cmd_r.addr[1:0]] <= byte_w;                           // [RULE14]
   end

   // -------------------------------------------------------------------------
   // Link side: flag byte out on falling serial clock edges
   // -------------------------------------------------------------------------
   always_ff @(negedge sck or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         stat_meta_r <= '0;
         stat_sync_r <= '0;
      end
      else
      begin
         stat_meta_r <= stat_w;
         stat_sync_r <= stat_meta_r;
      end
   end

   assign stat_byte_w = {`SEEW_FLAGS_PAD, stat_sync_r};               // [RULE1] [RULE4]

   always_ff @(negedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         so_r      <= 1'b0;
         so_oe_r   <= 1'b0;
         out_idx_r <= `SEEW_BIT_FIRST;
      end
      else if (state_r == LS_STAT)
      begin
         so_oe_r   <= 1'b1;
         so_r      <= stat_byte_w[`SEEW_BIT_LAST - out_idx_r];        // [RULE5] [RULE23]
         out_idx_r <= out_idx_r + `SEEW_BIT_STEP;
      end
      else
      begin
         so_oe_r <= 1'b0;                                             // [RULE21]
      end
   end

   assign so_out = so_r;
   assign so_oe  = so_oe_r;

   // -------------------------------------------------------------------------
   // System side: synchronisers and commit at chip select rise
   // -------------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      link_rst_r <= !reset_n;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         cs_meta_r   <= 1'b1;
         cs_sync_r   <= 1'b1;
         cs_prev_r   <= 1'b1;
         wp_meta_r   <= 1'b0;
         wp_sync_r   <= 1'b0;
         tog_meta_r  <= 1'b0;
         tog_sync_r  <= 1'b0;
         comp_meta_r <= 1'b0;
         comp_sync_r <= 1'b0;
      end
      else
      begin
         cs_meta_r   <= cs_n;
         cs_sync_r   <= cs_meta_r;
         cs_prev_r   <= cs_sync_r;
         wp_meta_r   <= wp_n;
         wp_sync_r   <= wp_meta_r;
         tog_meta_r  <= frame_tog_r;
         tog_sync_r  <= tog_meta_r;
         comp_meta_r <= complete_r;
         comp_sync_r <= comp_meta_r;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         tog_seen_r <= 1'b0;
      else if (cs_rise_w)
         tog_seen_r <= tog_sync_r;
   end

   // The command record is stable from the last serial edge until the next
   // frame, which cannot begin before the synchronised rise is seen here.
   assign cs_rise_w   = cs_sync_r && !cs_prev_r;
   assign commit_w    = cs_rise_w && (tog_sync_r != tog_seen_r) && comp_sync_r; // [RULE11]
   assign start_arr_w = commit_w && cmd_r.kind == CK_WRITE && !busy_w && wen_r &&
                        wp_sync_r && !seew_prot_hit(bp_r, cmd_r.addr);          // [RULE8] [RULE16]
   assign start_bp_w  = commit_w && cmd_r.kind == CK_FLAGS_WR && !busy_w &&
                        wen_r && wp_sync_r;                                     // [RULE18] [RULE24]

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         wen_r <= 1'b0;                                                      // [RULE6]
      else if (done_w)
         wen_r <= 1'b0;                                                      // [RULE15] [RULE20]
      else if (commit_w && !busy_w && cmd_r.kind == CK_ARM)
         wen_r <= 1'b1;                                                      // [RULE12]
      else if (commit_w && !busy_w && cmd_r.kind == CK_DISARM)
         wen_r <= 1'b0;                                                      // [RULE7]
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         bp_r <= `SEEW_BP_RESET;
      else if (start_bp_w)
         bp_r <= cmd_r.bp;                                                   // [RULE17]
   end

   assign stat_w = '{bp: bp_r, wen: wen_r, busy: busy_w};                    // [RULE2] [RULE3]

   // -------------------------------------------------------------------------
   // System side: page hand-off to the cell array
   // -------------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         wr_act_r  <= 1'b0;
         wr_idx_r  <= `SEEW_PAGE_FIRST;
         wr_base_r <= 9'h000;
         wr_mask_r <= `SEEW_PAGE_NONE;
      end
      else if (start_arr_w)
      begin
         wr_act_r  <= 1'b1;
         wr_idx_r  <= `SEEW_PAGE_FIRST;
         wr_base_r <= cmd_r.addr;
         wr_mask_r <= loaded_r;
      end
      else if (wr_act_r)
      begin
         wr_idx_r <= wr_idx_r + `SEEW_PAGE_STEP;
         if (wr_idx_r == `SEEW_PAGE_LAST)
            wr_act_r <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (start_arr_w)
         wr_page_r <= page_r;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         arr_wr_r <= '0;
      else
      begin
         arr_wr_r.en   <= wr_act_r && wr_mask_r[wr_idx_r];
         arr_wr_r.addr <= {wr_base_r[8:2], wr_idx_r};                        // [RULE14]
         arr_wr_r.data <= wr_page_r[wr_idx_r];
      end
   end

   assign array_wr = arr_wr_r;

   seew_prog_timer #(
      .PROG_CYCLES (PROG_CYCLES)
   ) u_timer (
      .clock   (clock),
      .reset_n (reset_n),
      .start   (start_arr_w || start_bp_w),
      .busy    (busy_w),
      .done    (done_w)
   );

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence s_idle_cmd(seew_kind_t k);
      commit_w && !busy_w && cmd_r.kind == k;
   endsequence

   sequence s_prog_start;
      start_arr_w || start_bp_w;
   endsequence

   AST_WEN_AFTER_RESET: assert property ($rose(reset_n) |-> !wen_r) // [RULE6]
      else $error("write arm latch set right after reset");
   AST_DISARM_CLEARS: assert property (s_idle_cmd(CK_DISARM) |=> !wen_r) // [RULE7]
      else $error("disarm left the latch set");
   AST_ARM_SETS: assert property (s_idle_cmd(CK_ARM) |=> wen_r && !busy_w) // [RULE2]
      else $error("arm did not set the latch");
   AST_START_GATED: assert property (s_prog_start |-> wen_r && wp_sync_r && !busy_w) // [RULE8]
      else $error("programming started without guard and arm");
   AST_PROT_RANGE: assert property (start_arr_w |-> !seew_prot_hit(bp_r, cmd_r.addr)) // [RULE9]
      else $error("write started inside protected range");
   AST_BUSY_HOLDS_BP: assert property (busy_w ##1 busy_w |-> $stable(bp_r)) // [RULE12]
      else $error("protect level changed while programming");
   AST_AUTO_DISARM: assert property (done_w |=> !wen_r ##1 !busy_w) // [RULE15]
      else $error("latch still set after programming");
   AST_BP_STORE: assert property (start_bp_w |=> bp_r == $past(cmd_r.bp) && busy_w) // [RULE17]
      else $error("protect level not stored at flag write");
   AST_BUSY_FOLLOWS: assert property (s_prog_start |=> busy_w [*2]) // [RULE3]
      else $error("busy flag missing after start");
   AST_PAGE_BLOCK: assert property (arr_wr_r.en |-> arr_wr_r.addr[8:2] == wr_base_r[8:2]) // [RULE14]
      else $error("page write left its four-byte block");

endmodule

`default_nettype wire

// ---- verification/seew_spi_master.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Serial bus master model
// ----------------------------------------------------------------------------
module seew_spi_master (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so_out,
   input  wire logic so_oe
);

   initial
   begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // The clock only runs inside a frame, so the link domain really goes quiet.
   // Odd gaps keep its phase drifting against the system clock.
   task automatic xfer(input logic [63:0] tx, input int nb, input int nrd,
                       output logic [7:0] rd, output logic oe_any);
      rd     = 8'h00;
      oe_any = 1'b0;
      cs_n   = 1'b0;
      #17.3;
      for (int i = 0; i < nb + nrd; i++)
      begin
         si = (i < nb) ? tx[63 - i] : ~si;
         #32;
         sck    = 1'b1;
         oe_any = oe_any | so_oe;
         rd     = {rd[6:0], so_out};
         #32;
         sck = 1'b0;
      end
      #13.1;
      cs_n = 1'b1;
      si   = ~si;
      #101.3;
   endtask

endmodule

`default_nettype wire

// ---- verification/serial_eeprom_write_status_cmds_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_write_status_cmds_bench;
   import seew_pkg::*;

   // -------------------------------------------------------------------------
   // Signals and instances
   // -------------------------------------------------------------------------
   localparam int unsigned PROG = 1000;
   logic         clock = 1'b0;
   logic         reset_n;
   logic         wp_n;
   wire  logic   sck;
   wire  logic   cs_n;
   wire  logic   si;
   logic         so_out;
   logic         so_oe;
   seew_arr_wr_t array_wr;
   int           miscompares = 0;
   int           checks_done = 0;
   int           cycles = 0;
   logic [16:0]  wr_q[$];
   logic [7:0]   v;
   logic         o;
   logic [1:0]   lv[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
   logic [8:0]   ad[6] = '{9'h1FC, 9'h180, 9'h17C, 9'h100, 9'h0FC, 9'h000};
   logic         okv[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [16:0]  pg[4] = '{{9'h17C, 8'h55}, {9'h17D, 8'h22}, {9'h17E, 8'h33}, {9'h17F, 8'h44}};

   always #2 clock = ~clock;

   seew_ctrl #(.PROG_CYCLES(PROG)) i_dut (.clock(clock), .reset_n(reset_n), .sck(sck),
      .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
      .array_wr(array_wr));

   seew_spi_master i_master (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
      .so_oe(so_oe));

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (array_wr.en === 1'b1)
         wr_q.push_back({array_wr.addr, array_wr.data});
      if (cycles == 60000)
      begin
         miscompares++;
         wrap_up();
      end
   end

   // -------------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------------
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send(input logic [63:0] tx, input int nb);
      logic [7:0] r;
      logic       e;
      i_master.xfer(tx, nb, 0, r, e);
   endtask

   task automatic rd_flags(output logic [7:0] f);
      logic e;
      i_master.xfer({8'h05, 56'h0}, 8, 8, f, e);
      check("flags_oe", e, 1'b1);
   endtask

   task automatic poll();
      logic [7:0] f;
      int         n;
      n = 0;
      f = 8'h01;
      while (f[0] !== 1'b0 && n < 20)
      begin
         rd_flags(f);
         n++;
      end
      check("ready", f[0], 1'b0);
   endtask

   task automatic set_level(input logic [1:0] lvl);
      logic [7:0] f;
      send({8'h06, 56'h0}, 8);
      send({8'h01, 4'hA, lvl, 2'h3, 48'h0}, 16);
      rd_flags(f);
      check("busy_flag", f[0], 1'b1);
      poll();
      rd_flags(f);
      check("level_flags", f, {4'h0, lvl, 2'h0});
   endtask

   // A refused write leaves the latch armed, an accepted one clears it at the end.
   task automatic try_write(input logic [8:0] a, input logic [7:0] d, input logic ok);
      logic [7:0] f;
      wr_q.delete();
      send({8'h06, 56'h0}, 8);
      send({4'h0, a[8], 3'h2, a[7:0], d, 40'h0}, 24);
      poll();
      rd_flags(f);
      check("wen_after", f[1], !ok);
      check("wr_count", 17'(wr_q.size()), ok);
      if (ok && wr_q.size() == 1)
         check("wr_cell", wr_q[0], {a, d});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------------------
   initial
   begin
      reset_n = 1'b0;
      wp_n    = 1'b1;
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      repeat (10) @(negedge clock);
      rd_flags(v);
      check("reset_flags", v, 8'h00);
      wr_q.delete();
      send({8'h02, 8'h10, 8'hA5, 40'h0}, 24);
      rd_flags(v);
      check("unarmed_write", {wr_q.size() == 0, v}, {1'b1, 8'h00});
      send({8'h06, 56'h0}, 8);
      rd_flags(v);
      check("armed", v, 8'h02);
      send({8'h02, 8'h40, 8'hC3, 40'h0}, 20);
      rd_flags(v);
      check("abort", {wr_q.size() == 0, v}, {1'b1, 8'h02});
      i_master.xfer({8'hFF, 56'h0}, 8, 8, v, o);
      check("invalid_oe", o, 1'b0);
      i_master.xfer({8'h03, 56'h0}, 8, 8, v, o);
      check("array_rd_oe", o, 1'b0);
      send({8'h04, 56'h0}, 8);
      rd_flags(v);
      check("disarmed", v, 8'h00);
      @(negedge clock);
      wp_n = 1'b0;
      send({8'h06, 56'h0}, 8);
      send({8'h01, 8'h0C, 48'h0}, 16);
      rd_flags(v);
      check("guard_flags", v, 8'h02);
      try_write(9'h020, 8'h3C, 1'b0);
      @(negedge clock);
      wp_n = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         set_level(lv[i]);
         try_write(ad[i], 8'h5A ^ 8'(i), okv[i]);
      end
      set_level(2'h1);
      wr_q.delete();
      send({8'h06, 56'h0}, 8);
      send({8'h0A, 8'h7C, 40'h1122334455, 8'h00}, 56);
      send({8'h02, 8'h00, 8'hEE, 40'h0}, 24);
      poll();
      check("page_count", 17'(wr_q.size()), 17'h4);
      foreach (pg[i])
         check("page_cell", wr_q[i], pg[i]);
      rd_flags(v);
      check("page_flags", v, 8'h04);
      wrap_up();
   end

endmodule

`default_nettype wire
